//--- srxc_div.sv
`timescale 1ns/10ps
`default_nettype none
module srxc_div
  import srxc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic run,
  input wire logic [7:0] divisor,
  // One-cycle rate enable
  output logic tick
);

  typedef struct packed
  {
    logic [7:0] cnt;
    logic tick;
  } srxc_div_st_t;

  srxc_div_st_t cur_ff;
  srxc_div_st_t nxt_cur;

  // Tick every divisor+1 cycles while running
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.tick = 1'b0;
    if (!run)
      nxt_cur.cnt = 8'h00;
    else if (cur_ff.cnt >= divisor)
    begin
      nxt_cur.cnt = 8'h00;
      nxt_cur.tick = 1'b1;
    end
    else
      nxt_cur.cnt = cur_ff.cnt + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign tick = cur_ff.tick;

endmodule // srxc_div
`default_nettype wire

//--- srxc_peer.sv
`timescale 1ns/10ps
`default_nettype none
module srxc_peer #(parameter int BIT_CYC = 16)
(
  // Device side
  input wire logic pclk,
  input wire logic tx_clk_pin_out,
  input wire logic tx_clk_pin_oe,
  // Peer drive
  output logic rx_data_pin_in,
  output logic tx_clk_pin_in
);
  logic bits_q[$];
  initial
  begin
    rx_data_pin_in = 1'b1;
    tx_clk_pin_in = 1'b0;
  end
  // Async frame, idle high
  task automatic send_async(input logic [8:0] d, input int n);
    rx_data_pin_in <= 1'b0;
    repeat (BIT_CYC) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      rx_data_pin_in <= d[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    rx_data_pin_in <= 1'b1;
    repeat (BIT_CYC) @(posedge pclk);
  endtask
  // Word for a master clock, LSB first
  task automatic queue_word(input logic [7:0] w, input logic first);
    for (int i = 0; i < 8; i++)
      if (i == 0 && first)
        rx_data_pin_in <= w[0];
      else
        bits_q.push_back(w[i]);
  endtask
  always @(negedge tx_clk_pin_out)
    if (tx_clk_pin_oe === 1'b1)
      rx_data_pin_in <= bits_q.size() > 0 ? bits_q.pop_front() : ~rx_data_pin_in;
  // Slave word on a 64 ns link clock, still between words
  task automatic send_slave(input logic [7:0] w);
    for (int i = 0; i < 8; i++)
    begin
      rx_data_pin_in = w[i];
      #32 tx_clk_pin_in = 1'b1;
      #32 tx_clk_pin_in = 1'b0;
    end
    rx_data_pin_in = ~w[7];
  endtask
endmodule // srxc_peer
`default_nettype wire

//--- srxc_pkg.sv
package srxc_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [4:0] OFS_RX_STAT_CTL = 5'h00;
  localparam logic [4:0] OFS_RX_DATA = 5'h04;
  localparam logic [4:0] OFS_MODE = 5'h08;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

  // ****************************************************************
  // Receive status and control fields
  // ****************************************************************
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_RX9 = 6;
  localparam int BIT_SINGLE_RECEIVE_ENABLE = 5;
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int BIT_ADDRESS_DETECT_ENABLE = 3;
  localparam int BIT_FRAMING_ERROR_FLAG = 2;
  localparam int BIT_OVERRUN_ERROR_FLAG = 1;
  localparam int BIT_RECEIVED_NINTH_BIT = 0;

  // Mode register fields
  localparam int BIT_SYNC = 0;
  localparam int BIT_MASTER = 1;
  localparam int DIV_LSB = 8;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Interrupt status fields
  localparam int IRQ_W = 3;
  localparam int IRQ_RXLOAD = 0;
  localparam int IRQ_OVERRUN = 1;
  localparam int IRQ_FRAMING = 2;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  typedef enum logic [1:0]
  {
    SRXC_IDLE = 2'b00,
    SRXC_START = 2'b01,
    SRXC_DATA = 2'b11,
    SRXC_STOP = 2'b10
  } srxc_state_t;

endpackage

//--- srxc_props.sv
`timescale 1ns/10ps
`default_nettype none
module srxc_props
  import srxc_pkg::*;
(
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [4:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pins and interrupt
  input wire logic tx_clk_pin_out,
  input wire logic tx_clk_pin_oe,
  input wire logic pins_to_port,
  input wire logic rx_irq
);
  logic [7:0] ctl_ff;
  logic [1:0] mode_ff;
  logic [3:0] rise_ff;
  logic clk_ff;
  logic acc;
  logic serial_port_enable;
  logic drv;
  logic rd_ctl;
  assign acc = psel && penable && pready;
  assign serial_port_enable = ctl_ff[BIT_SERIAL_PORT_ENABLE];
  assign drv = serial_port_enable && mode_ff == 2'h3;
  assign rd_ctl = acc && !pwrite && paddr == OFS_RX_STAT_CTL;
  // ****************************************
  // Shadow of written controls
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_ff <= 8'h00;
      mode_ff <= 2'h0;
      rise_ff <= 4'h0;
      clk_ff <= 1'b0;
    end
    else
    begin
      clk_ff <= tx_clk_pin_out;
      if (acc && pwrite && paddr == OFS_MODE)
        mode_ff <= pwdata[1:0];
      if (acc && pwrite && paddr == OFS_RX_STAT_CTL)
      begin
        ctl_ff <= pwdata[7:0];
        rise_ff <= 4'h0;
      end
      else if (tx_clk_pin_out && !clk_ff && rise_ff != 4'hF)
        rise_ff <= rise_ff + 4'h1;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  port_pins_a: assert property (pins_to_port == serial_port_enable)
    else $error("pin ownership off");
  clk_drive_a: assert property (tx_clk_pin_oe == drv)
    else $error("clock pin drive off");
  clk_idle_a: assert property (!serial_port_enable |=> !tx_clk_pin_out)
    else $error("clock runs while disabled");
  flags_reset_a: assert property (rd_ctl && !serial_port_enable |-> prdata[2:1] == 2'h0)
    else $error("error flags set while disabled");
  nine_readback_a: assert property (rd_ctl |-> prdata[BIT_RX9] == ctl_ff[BIT_RX9])
    else $error("nine bit select lost");
  continuous_receive_enable_readback_a: assert property (rd_ctl |-> prdata[BIT_CONTINUOUS_RECEIVE_ENABLE] == ctl_ff[BIT_CONTINUOUS_RECEIVE_ENABLE])
    else $error("continuous enable lost");
  single_count_a: assert property (
    serial_port_enable && !ctl_ff[BIT_CONTINUOUS_RECEIVE_ENABLE] |-> rise_ff <= (ctl_ff[BIT_RX9] ? 4'h9 : 4'h8))
    else $error("more than one word clocked");
  reset_quiet_a: assert property ($rose(presetn) |-> !pins_to_port && !rx_irq)
    else $error("outputs active after reset");
endmodule // srxc_props
bind srxc_top srxc_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .tx_clk_pin_out(tx_clk_pin_out), .tx_clk_pin_oe(tx_clk_pin_oe),
  .pins_to_port(pins_to_port), .rx_irq(rx_irq));
`default_nettype wire

//--- srxc_sync.sv
`timescale 1ns/10ps
`default_nettype none
module srxc_sync
  import srxc_pkg::*;
#(
  parameter int W = 2
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } srxc_sync_st_t;

  srxc_sync_st_t cur_ff;
  srxc_sync_st_t nxt_cur;

  always_comb
  begin
    nxt_cur.meta = async_in;
    nxt_cur.stable = cur_ff.meta;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign sync_out = cur_ff.stable;

endmodule // srxc_sync
`default_nettype wire

//--- srxc_top.sv
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Port enable hands both pins to port
// - Port disabled holds receive logic in reset
// - Select bit picks nine or eight bits
// - Sync master single receive, self-clearing
// - Async continuous enable switches receiver
// - Sync continuous receive until bit cleared
// - Continuous overrides single in sync mode
// - Address detect loads only ninth-bit-one frames (async nine-bit mode only)
// - No address detect accepts every frame
module srxc_top
  import srxc_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [4:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic rx_data_pin_in,
  input wire logic tx_clk_pin_in,
  output logic tx_clk_pin_out,
  output logic tx_clk_pin_oe,
  output logic pins_to_port,
  // Interrupt
  output logic rx_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic serial_port_enable;
    logic rx9;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic received_ninth_bit;
    logic sync_mode;
    logic master;
    logic [7:0] divisor;
    logic [7:0] data;
    logic full;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_mask;
    srxc_state_t state;
    logic [3:0] ovs;
    logic [3:0] bitn;
    logic [8:0] shift;
    logic sclk_prev;
    logic sclk_out;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic clk_oe;
    logic pin_own;
  } srxc_st_t;

  srxc_st_t cur_ff;
  srxc_st_t nxt_cur;

  logic [1:0] pins_sync;
  logic rx_s;
  logic sclk_s;
  logic tick;
  logic div_run;

  function automatic logic [3:0] frame_bits(input logic nine);
    frame_bits = nine ? BITS_9 : BITS_8;
  endfunction

  // ****************************************************************
  // Pin synchronisers and rate divider
  // ****************************************************************
  srxc_sync #(.W(2)) u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({tx_clk_pin_in, rx_data_pin_in}),
    .sync_out(pins_sync)
  );

  assign rx_s = pins_sync[0];
  assign sclk_s = pins_sync[1];
  assign div_run = cur_ff.serial_port_enable && (cur_ff.state != SRXC_IDLE || !cur_ff.sync_mode);

  srxc_div u_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .run(div_run),
    .divisor(cur_ff.divisor),
    .tick(tick)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic acc;
    logic wr;
    logic done;
    logic stop_bit;
    logic [8:0] word;
    logic sample;
    logic rx_on;
    logic [IRQ_W-1:0] ev;
    logic [3:0] last_bit;
    acc = 1'b0;
    wr = 1'b0;
    done = 1'b0;
    stop_bit = 1'b1;
    word = 9'h000;
    sample = 1'b0;
    rx_on = 1'b0;
    ev = '0;
    last_bit = 4'h0;
    nxt_cur = cur_ff;
    nxt_cur.pready = 1'b0;
    nxt_cur.pslverr = 1'b0;
    nxt_cur.sclk_prev = sclk_s;
    last_bit = frame_bits(cur_ff.rx9) - 4'h1;

    // Receiver enable by mode
    if (!cur_ff.sync_mode)
      rx_on = cur_ff.continuous_receive_enable && !cur_ff.overrun_error_flag;
    else if (cur_ff.master)
      rx_on = (cur_ff.continuous_receive_enable || cur_ff.single_receive_enable) && !cur_ff.overrun_error_flag;
    else
      rx_on = cur_ff.continuous_receive_enable && !cur_ff.overrun_error_flag;

    // Sync sample point: master rising edge made here, slave edge seen
    if (cur_ff.master)
      sample = tick && !cur_ff.sclk_out;
    else
      sample = sclk_s && !cur_ff.sclk_prev;

    // ****************************************************************
    // Receive sequencer
    // ****************************************************************
    if (!rx_on)
    begin
      nxt_cur.state = SRXC_IDLE;
      nxt_cur.sclk_out = 1'b0;
    end
    else if (!cur_ff.sync_mode)
    begin
      unique case (cur_ff.state)
        SRXC_IDLE:
        begin
          nxt_cur.ovs = 4'h0;
          if (!rx_s)
            nxt_cur.state = SRXC_START;
        end
        SRXC_START:
        begin
          if (tick)
          begin
            nxt_cur.ovs = cur_ff.ovs + 4'h1;
            if (cur_ff.ovs == OVS_MID)
            begin
              nxt_cur.ovs = 4'h0;
              nxt_cur.bitn = 4'h0;
              nxt_cur.state = rx_s ? SRXC_IDLE : SRXC_DATA;
            end
          end
        end
        SRXC_DATA:
        begin
          if (tick)
          begin
            nxt_cur.ovs = cur_ff.ovs + 4'h1;
            if (cur_ff.ovs == OVS_LAST)
            begin
              nxt_cur.shift = {rx_s, cur_ff.shift[8:1]};
              nxt_cur.bitn = cur_ff.bitn + 4'h1;
              if (cur_ff.bitn == last_bit)
                nxt_cur.state = SRXC_STOP;
            end
          end
        end
        SRXC_STOP:
        begin
          if (tick)
          begin
            nxt_cur.ovs = cur_ff.ovs + 4'h1;
            if (cur_ff.ovs == OVS_LAST)
            begin
              done = 1'b1;
              stop_bit = rx_s;
              nxt_cur.state = SRXC_IDLE;
            end
          end
        end
      endcase
    end
    else
    begin
      if (cur_ff.state == SRXC_IDLE)
      begin
        nxt_cur.state = SRXC_DATA;
        nxt_cur.bitn = 4'h0;
        nxt_cur.sclk_out = 1'b0;
      end
      else
      begin
        if (cur_ff.master && tick)
          nxt_cur.sclk_out = !cur_ff.sclk_out;
        if (sample)
        begin
          nxt_cur.shift = {rx_s, cur_ff.shift[8:1]};
          nxt_cur.bitn = cur_ff.bitn + 4'h1;
          if (cur_ff.bitn == last_bit)
          begin
            done = 1'b1;
            nxt_cur.bitn = 4'h0;
            if (!cur_ff.continuous_receive_enable)
            begin
              nxt_cur.single_receive_enable = 1'b0;
              nxt_cur.state = SRXC_IDLE;
            end
            // Continuous wins; single request left alone
          end
        end
      end
    end

    // Assemble received word, LSB first
    word = cur_ff.rx9 ? nxt_cur.shift : {1'b0, nxt_cur.shift[8:1]};

    // ****************************************************************
    // Frame completion
    // ****************************************************************
    if (done)
    begin
      if (cur_ff.full)
      begin
        nxt_cur.overrun_error_flag = 1'b1;
        ev[IRQ_OVERRUN] = 1'b1;
      end
      else if (!cur_ff.sync_mode && cur_ff.rx9 && cur_ff.address_detect_enable && !word[8])
        nxt_cur.full = 1'b0;
      else
      begin
        nxt_cur.data = word[7:0];
        nxt_cur.received_ninth_bit = word[8];
        nxt_cur.framing_error_flag = !stop_bit;
        nxt_cur.full = 1'b1;
        ev[IRQ_RXLOAD] = 1'b1;
        ev[IRQ_FRAMING] = !stop_bit;
      end
    end

    // ****************************************************************
    // APB access
    // ****************************************************************
    acc = psel && penable;
    wr = acc && pwrite && cur_ff.pready;
    if (acc && !cur_ff.pready)
    begin
      nxt_cur.pready = 1'b1;
      nxt_cur.prdata = 32'h0000_0000;
      unique case (paddr)
        OFS_RX_STAT_CTL:
          nxt_cur.prdata[7:0] = {cur_ff.serial_port_enable, cur_ff.rx9, cur_ff.single_receive_enable, cur_ff.continuous_receive_enable,
                                 cur_ff.address_detect_enable, cur_ff.framing_error_flag, cur_ff.overrun_error_flag, cur_ff.received_ninth_bit};
        OFS_RX_DATA:
        begin
          nxt_cur.prdata[7:0] = cur_ff.data;
          if (!pwrite)
            nxt_cur.full = 1'b0;
        end
        OFS_MODE:
        begin
          nxt_cur.prdata[BIT_SYNC] = cur_ff.sync_mode;
          nxt_cur.prdata[BIT_MASTER] = cur_ff.master;
          nxt_cur.prdata[DIV_LSB+7:DIV_LSB] = cur_ff.divisor;
        end
        OFS_IRQ_STAT:
          nxt_cur.prdata[IRQ_W-1:0] = cur_ff.irq_st;
        OFS_IRQ_MASK:
          nxt_cur.prdata[IRQ_W-1:0] = cur_ff.irq_mask;
        default:
          nxt_cur.pslverr = 1'b1;
      endcase
    end

    if (wr)
    begin
      unique case (paddr)
        OFS_RX_STAT_CTL:
        begin
          // Status fields ignore writes; overrun clears when continuous enable is written 0
          nxt_cur.serial_port_enable = pwdata[BIT_SERIAL_PORT_ENABLE];
          nxt_cur.rx9 = pwdata[BIT_RX9];
          nxt_cur.single_receive_enable = pwdata[BIT_SINGLE_RECEIVE_ENABLE];
          nxt_cur.continuous_receive_enable = pwdata[BIT_CONTINUOUS_RECEIVE_ENABLE];
          nxt_cur.address_detect_enable = pwdata[BIT_ADDRESS_DETECT_ENABLE];
          if (!pwdata[BIT_CONTINUOUS_RECEIVE_ENABLE])
            nxt_cur.overrun_error_flag = 1'b0;
        end
        OFS_MODE:
        begin
          nxt_cur.sync_mode = pwdata[BIT_SYNC];
          nxt_cur.master = pwdata[BIT_MASTER];
          nxt_cur.divisor = pwdata[DIV_LSB+7:DIV_LSB];
        end
        OFS_IRQ_STAT:
          nxt_cur.irq_st = cur_ff.irq_st & ~pwdata[IRQ_W-1:0];
        OFS_IRQ_MASK:
          nxt_cur.irq_mask = pwdata[IRQ_W-1:0];
        default:
          nxt_cur.irq_mask = nxt_cur.irq_mask;
      endcase
    end

    // Events beat a same-cycle clear
    nxt_cur.irq_st = nxt_cur.irq_st | ev;

    // ****************************************************************
    // Port disable holds receive side in reset
    // ****************************************************************
    if (!nxt_cur.serial_port_enable)
    begin
      nxt_cur.state = SRXC_IDLE;
      nxt_cur.ovs = 4'h0;
      nxt_cur.bitn = 4'h0;
      nxt_cur.shift = 9'h000;
      nxt_cur.sclk_out = 1'b0;
      nxt_cur.full = 1'b0;
      nxt_cur.framing_error_flag = 1'b0;
      nxt_cur.overrun_error_flag = 1'b0;
      nxt_cur.single_receive_enable = 1'b0;
    end

    nxt_cur.pin_own = nxt_cur.serial_port_enable;
    nxt_cur.clk_oe = nxt_cur.serial_port_enable && nxt_cur.sync_mode && nxt_cur.master;
    nxt_cur.irq = |(nxt_cur.irq_st & nxt_cur.irq_mask);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_ff <= '0;
      cur_ff.divisor <= DIV_RESET;
      cur_ff.state <= SRXC_IDLE;
    end
    else
      cur_ff <= nxt_cur;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign tx_clk_pin_out = cur_ff.sclk_out;
  assign tx_clk_pin_oe = cur_ff.clk_oe;
  assign pins_to_port = cur_ff.pin_own;
  assign rx_irq = cur_ff.irq;

endmodule // srxc_top
`default_nettype wire

//--- testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
  import srxc_pkg::*;
  ;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [4:0] paddr = 5'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic [8:0] d;
  logic pready, pslverr, slv, rx_data_pin_in, tx_clk_pin_in;
  logic tx_clk_pin_out, tx_clk_pin_oe, pins_to_port, rx_irq, ld;
  int err_count = 0;
  int total_checks = 0;
  int seed = 32'hA0F4;
  int n;
  int exp_q[$];
  always #2.5 pclk = ~pclk;
  srxc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_data_pin_in(rx_data_pin_in), .tx_clk_pin_in(tx_clk_pin_in),
    .tx_clk_pin_out(tx_clk_pin_out), .tx_clk_pin_oe(tx_clk_pin_oe),
    .pins_to_port(pins_to_port), .rx_irq(rx_irq));
  srxc_peer peer_u (.pclk(pclk), .tx_clk_pin_out(tx_clk_pin_out),
    .tx_clk_pin_oe(tx_clk_pin_oe), .rx_data_pin_in(rx_data_pin_in),
    .tx_clk_pin_in(tx_clk_pin_in));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] v);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    q = prdata;
    slv = pslverr;
    err_count += (k == 20);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 600 && rx_irq !== 1'b1; k++)
      @(posedge pclk);
  endtask
  task automatic pop_data();
    apb(0, OFS_RX_DATA, 0);
    check("data", exp_q.pop_front(), q);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    err_count++;
    wrap_up();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, OFS_RX_STAT_CTL, 0);
    check("ctl", 0, q & 32'hFE);
    apb(0, 5'h14, 0);
    check("slverr", 1, slv);
    apb(1, OFS_RX_STAT_CTL, 32'hFF);
    apb(0, OFS_RX_STAT_CTL, 0);
    check("ctl", 32'hF8, q & 32'hFE);
    check("pins", 1, pins_to_port);
    apb(1, OFS_IRQ_MASK, 32'h7);
    for (int c = 0; c < 3; c++)
    begin
      apb(1, OFS_RX_STAT_CTL, 32'h90 | (c > 0 ? 32'h40 : 0) | (c == 2 ? 32'h08 : 0));
      for (int i = 0; i < 2; i++)
      begin
        d = {i[0], 8'($random(seed))};
        ld = c < 2 || d[8];
        peer_u.send_async(d, c > 0 ? 9 : 8);
        if (ld)
          exp_q.push_back(d[7:0]);
        wait_irq();
        apb(0, OFS_IRQ_STAT, 0);
        check("load", ld, q);
        apb(0, OFS_RX_STAT_CTL, 0);
        if (ld && c > 0)
          check("ninth", d[8], q[BIT_RECEIVED_NINTH_BIT]);
        if (ld)
          pop_data();
        apb(1, OFS_IRQ_STAT, 32'h7);
        @(posedge pclk);
        check("irq", 0, rx_irq);
      end
    end
    apb(1, OFS_IRQ_MASK, 0);
    apb(1, OFS_RX_STAT_CTL, 32'h90);
    for (int i = 0; i < 2; i++)
    begin
      d = 9'($random(seed));
      peer_u.send_async(d, 8);
      if (i == 0)
        exp_q.push_back(d[7:0]);
    end
    repeat (20) @(posedge pclk);
    check("irq", 0, rx_irq);
    apb(0, OFS_RX_STAT_CTL, 0);
    check("ovr", 1, q[BIT_OVERRUN_ERROR_FLAG]);
    apb(1, OFS_IRQ_MASK, 32'h7);
    @(posedge pclk);
    check("irq", 1, rx_irq);
    pop_data();
    apb(1, OFS_RX_STAT_CTL, 32'h80);
    apb(1, OFS_IRQ_STAT, 32'h7);
    apb(0, OFS_RX_STAT_CTL, 0);
    check("ovr", 0, q[BIT_OVERRUN_ERROR_FLAG]);
    peer_u.send_async(9'h055, 8);
    repeat (40) @(posedge pclk);
    apb(0, OFS_IRQ_STAT, 0);
    check("off", 0, q);
    apb(1, OFS_MODE, 32'h0703);
    for (int w = 0; w < 3; w++)
    begin
      d = 9'($random(seed));
      peer_u.queue_word(d[7:0], w != 2);
      exp_q.push_back(d[7:0]);
      if (w == 0)
      begin
        apb(1, OFS_RX_STAT_CTL, 32'hA0);
        wait_irq();
        apb(1, OFS_IRQ_STAT, 32'h7);
        pop_data();
        apb(0, OFS_RX_STAT_CTL, 0);
        check("single", 0, q[BIT_SINGLE_RECEIVE_ENABLE]);
      end
    end
    // Both words queued back to back before continuous receive starts
    apb(1, OFS_RX_STAT_CTL, 32'hB0);
    for (int w = 1; w < 3; w++)
    begin
      wait_irq();
      apb(1, OFS_IRQ_STAT, 32'h7);
      pop_data();
    end
    apb(1, OFS_RX_STAT_CTL, 32'h80);
    repeat (200) @(posedge pclk);
    n = 0;
    repeat (40)
    begin
      @(posedge pclk);
      n += tx_clk_pin_out;
    end
    check("clk stop", 0, n);
    apb(0, OFS_RX_DATA, 0);
    apb(1, OFS_MODE, 32'h01);
    apb(1, OFS_IRQ_STAT, 32'h7);
    apb(1, OFS_RX_STAT_CTL, 32'h90);
    check("oe", 0, tx_clk_pin_oe);
    d = 9'($random(seed));
    exp_q.push_back(d[7:0]);
    peer_u.send_slave(d[7:0]);
    wait_irq();
    pop_data();
    apb(1, OFS_RX_STAT_CTL, 0);
    apb(0, OFS_RX_STAT_CTL, 0);
    check("ctl", 0, q & 32'hFE);
    check("pins", 0, pins_to_port);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
